// File: dv/pdao_obs.sv
// Far-side observer: a lamp wired across the relay contacts.
// Assumes contact levels come straight from the block's registers.
`timescale 1ns/1ns
module pdao_obs
(
	// Relay contacts
	input wire logic closed_in,
	input wire logic open_in,
	// Lamp state
	output logic lamp_out
);
	// Lamp lit only when closed contact made and open contact broken
	assign lamp_out = closed_in & ~open_in;
endmodule // pdao_obs

// File: dv/tb_pdao_top.sv
// Bench for the deviation flag, trip alarm and terminal routing.
// Assumes the design package and the lamp observer are compiled first.
`timescale 1ns/1ns
module tb_pdao_top;
	// ****************************************
	// Stimulus and observed signals
	// ****************************************
	logic clk_in = 1'b0;
	logic sys_rst_in = 1'b1;
	logic thresh_wr_in = 1'b0;
	logic fault_event_in = 1'b0;
	logic fault_clear_in = 1'b0;
	logic sel_wr_in = 1'b0;
	logic [15:0] setpoint_in = 16'h0000;
	logic [15:0] process_in = 16'h0000;
	logic [15:0] thresh_data_in = 16'h0000;
	logic [1:0] oc1_sel_in = pdao_pkg::FN_DEV;
	logic [1:0] oc2_sel_in = pdao_pkg::FN_OFF;
	logic [1:0] relay_sel_in = pdao_pkg::FN_ALARM;
	logic dev_w, alarm_w, oc1_w, oc2_w, cl_w, op_w, lamp_w;
	logic [15:0] thr_w;
	int bad_count = 0;
	int comparisons = 0;
	// Setpoint, process value and expected flag per step
	// Listed from the last step down to the first
	localparam logic [5:0][15:0] SP = {16'h0258, 16'h0258, 16'h03E8,
		16'h03E8, 16'h03E8, 16'h03E8};
	localparam logic [5:0][15:0] PV = {16'h0384, 16'h03E8, 16'h02BD,
		16'h02BC, 16'h0258, 16'h02BC};
	// Bit i is the flag at step i; step 5 holds at equal error
	localparam logic [5:0] EXP = 6'h36;
	// Free-running clock
	always #10 clk_in = ~clk_in;
	pdao_top i_dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
		.setpoint_in(setpoint_in), .process_in(process_in),
		.thresh_wr_in(thresh_wr_in), .thresh_data_in(thresh_data_in),
		.fault_event_in(fault_event_in), .fault_clear_in(fault_clear_in),
		.oc1_sel_in(oc1_sel_in), .oc2_sel_in(oc2_sel_in),
		.relay_sel_in(relay_sel_in), .sel_wr_in(sel_wr_in),
		.loop_deviation_flag_out(dev_w), .fault_alarm_flag_out(alarm_w),
		.deviation_threshold_param_out(thr_w), .oc1_term_out(oc1_w),
		.oc2_term_out(oc2_w), .relay_contact_closed_on_alarm_out(cl_w),
		.relay_contact_open_on_alarm_out(op_w));
	pdao_obs i_obs (.closed_in(cl_w), .open_in(op_w), .lamp_out(lamp_w));
	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic step(input int n);
		repeat (n) @(posedge clk_in);
		#2;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			bad_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic report_and_stop;
		$display("bad_count=%0d comparisons=%0d", bad_count, comparisons);
		if (bad_count == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_reset;
		chk(thr_w, pdao_pkg::THRESH_RST);
		chk(16'(dev_w | alarm_w | cl_w | oc1_w | oc2_w), 16'h0000);
		chk(16'(op_w), 16'h0001);
	endtask
	task automatic t_dev;
		for (int i = 0; i < 6; i++)
		begin
			setpoint_in = SP[i];
			process_in = PV[i];
			step(1);
			chk(16'(dev_w), 16'(EXP[i]));
			step(1);
			chk(16'(oc1_w), 16'(EXP[i]));
		end
	endtask
	task automatic t_thr;
		process_in = 16'h03E8;
		thresh_data_in = 16'h01F4;
		thresh_wr_in = 1'b1;
		step(1);
		thresh_wr_in = 1'b0;
		chk(thr_w, 16'h01F4);
		step(1);
		chk(16'(dev_w), 16'h0000);
	endtask
	task automatic t_alarm;
		fault_event_in = 1'b1;
		step(1);
		fault_event_in = 1'b0;
		chk(16'({alarm_w, cl_w, op_w, lamp_w}), 16'h000D);
		step(4);
		chk(16'(alarm_w), 16'h0001);
		fault_clear_in = 1'b1;
		fault_event_in = 1'b1;
		step(1);
		fault_event_in = 1'b0;
		chk(16'(alarm_w), 16'h0001);
		step(1);
		fault_clear_in = 1'b0;
		chk(16'({alarm_w, lamp_w}), 16'h0000);
	endtask
	task automatic t_route;
		oc1_sel_in = pdao_pkg::FN_OFF;
		oc2_sel_in = pdao_pkg::FN_ALARM;
		relay_sel_in = pdao_pkg::FN_DEV;
		sel_wr_in = 1'b1;
		step(1);
		sel_wr_in = 1'b0;
		fault_event_in = 1'b1;
		step(1);
		fault_event_in = 1'b0;
		step(1);
		chk(16'({oc1_w, oc2_w, cl_w}), 16'h0002);
		// Deviation on: relay follows it two edges late, off gates
		process_in = 16'h0000;
		step(3);
		chk(16'({oc1_w, cl_w, op_w}), 16'h0002);
		// Spare code is off, deviation to two, alarm back on relay
		oc1_sel_in = 2'h3;
		oc2_sel_in = pdao_pkg::FN_DEV;
		relay_sel_in = pdao_pkg::FN_ALARM;
		sel_wr_in = 1'b1;
		fault_clear_in = 1'b1;
		step(1);
		sel_wr_in = 1'b0;
		fault_clear_in = 1'b0;
		chk(16'({cl_w, op_w}), 16'h0001);
		step(1);
		chk(16'({oc1_w, oc2_w, cl_w}), 16'h0002);
	endtask
	task automatic t_rerst;
		sys_rst_in = 1'b1;
		step(2);
		chk(16'({alarm_w, dev_w, oc2_w, cl_w, op_w}), 16'h0001);
		sys_rst_in = 1'b0;
		fault_event_in = 1'b1;
		step(1);
		fault_event_in = 1'b0;
		chk(thr_w, pdao_pkg::THRESH_RST);
		chk(16'({alarm_w, cl_w, op_w, dev_w}), 16'h000D);
	endtask
	// Main sequence: reset for three cycles, then scenarios
	initial
	begin
		step(3);
		sys_rst_in = 1'b0;
		t_reset();
		t_dev();
		t_thr();
		t_alarm();
		t_route();
		t_rerst();
		report_and_stop();
	end
endmodule // tb_pdao_top

// File: hw/pdao_pkg.sv
// Constants for the PID deviation and fault alarm output block.
// Assumes error values are unsigned percent-scaled integers.
// What this block does
// - Error is absolute setpoint minus process variable
// - Deviation flag on when error above threshold
// - Deviation flag off when error below threshold
// - Threshold resets to three percent, software writable
// - Alarm active while tripped after a fault
// - Alarm inactive once the fault is cleared
// - Alarm routable to either collector or relay
// - Relay carries alarm function after reset
// - Alarm on from occurrence until cleared
package pdao_pkg;
	// ****************************************
	// Widths and reset values
	// ****************************************
	localparam int VAL_W = 16;
	// Scale: 100 percent equals 10000 counts (0.01 percent steps)
	localparam logic [15:0] THRESH_RST = 16'h012C; // 3.00 percent
	// Output function selector codes
	localparam int SEL_W = 2;
	localparam logic [1:0] FN_OFF = 2'h0;
	localparam logic [1:0] FN_DEV = 2'h1;
	localparam logic [1:0] FN_ALARM = 2'h2;
	localparam logic [1:0] OC1_RST = FN_DEV;
	localparam logic [1:0] OC2_RST = FN_OFF;
	localparam logic [1:0] RELAY_RST = FN_ALARM;
endpackage

// File: hw/pdao_route.sv
// One output terminal: picks a function by its selector code.
// Assumes selector and function levels are synchronous to clk_in.
`timescale 1ns/1ns
module pdao_route
(
	// Clock and reset
	input wire logic clk_in,
	input wire logic sys_rst_in,
	// Function select and sources
	input wire logic [1:0] sel_in,
	input wire logic dev_in,
	input wire logic alarm_in,
	// Terminal level
	output logic term_out
);
	typedef struct packed
	{
		logic term;
	} pdao_route_st_t;
	pdao_route_st_t st_q;
	pdao_route_st_t st_d;

	// Selector mux
	always_comb
	begin
		st_d = st_q;
		case (sel_in)
			pdao_pkg::FN_DEV: st_d.term = dev_in;
			pdao_pkg::FN_ALARM: st_d.term = alarm_in;
			default: st_d.term = 1'b0;
		endcase
	end

	// State register
	always_ff @(posedge clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
			st_q <= '0;
		else
			st_q <= st_d;
	end

	assign term_out = st_q.term;
endmodule // pdao_route

// File: hw/pdao_top.sv
// Deviation comparator, trip alarm and terminal routing.
// Assumes setpoint, process value and fault inputs are synchronous.
`timescale 1ns/1ns
module pdao_top
#(
	parameter int VAL_W = pdao_pkg::VAL_W
)
(
	// Clock and reset
	input wire logic clk_in,
	input wire logic sys_rst_in,
	// Loop values
	input wire logic [VAL_W-1:0] setpoint_in,
	input wire logic [VAL_W-1:0] process_in,
	// Threshold write port
	input wire logic thresh_wr_in,
	input wire logic [VAL_W-1:0] thresh_data_in,
	// Fault events
	input wire logic fault_event_in,
	input wire logic fault_clear_in,
	// Terminal function selectors
	input wire logic [1:0] oc1_sel_in,
	input wire logic [1:0] oc2_sel_in,
	input wire logic [1:0] relay_sel_in,
	input wire logic sel_wr_in,
	// Flags and terminals
	output logic loop_deviation_flag_out,
	output logic fault_alarm_flag_out,
	output logic [VAL_W-1:0] deviation_threshold_param_out,
	output logic oc1_term_out,
	output logic oc2_term_out,
	output logic relay_contact_closed_on_alarm_out,
	output logic relay_contact_open_on_alarm_out
);
	// ****************************************
	// Parameter check
	// ****************************************
	if (VAL_W < 16)
	begin : g_bad_width
		$error("VAL_W must be at least 16");
	end

	typedef struct packed
	{
		logic [VAL_W-1:0] thresh;
		logic dev;
		logic alarm;
		logic [1:0] oc1_sel;
		logic [1:0] oc2_sel;
		logic [1:0] relay_sel;
		logic rly_cl;
		logic rly_op;
	} pdao_st_t;
	pdao_st_t st_q;
	pdao_st_t st_d;
	logic [VAL_W-1:0] err_mag;
	logic relay_lvl;

	// ****************************************
	// Error magnitude
	// ****************************************
	// Absolute difference, never negative
	always_comb
	begin
		if (setpoint_in >= process_in)
			err_mag = setpoint_in - process_in;
		else
			err_mag = process_in - setpoint_in;
	end

	// ****************************************
	// Next state
	// ****************************************
	always_comb
	begin
		st_d = st_q;
		if (thresh_wr_in)
			st_d.thresh = thresh_data_in;
		if (err_mag > st_q.thresh)
			st_d.dev = 1'b1;
		else if (err_mag < st_q.thresh)
			st_d.dev = 1'b0;
		// Fault set wins over a clear in the same cycle
		if (fault_event_in)
			st_d.alarm = 1'b1;
		else if (fault_clear_in)
			st_d.alarm = 1'b0;
		if (sel_wr_in)
		begin
			st_d.oc1_sel = oc1_sel_in;
			st_d.oc2_sel = oc2_sel_in;
			st_d.relay_sel = relay_sel_in;
		end
		// Contacts follow the next alarm level when the relay carries it
		if (st_d.relay_sel == pdao_pkg::FN_ALARM)
			st_d.rly_cl = st_d.alarm;
		else
			st_d.rly_cl = relay_lvl;
		st_d.rly_op = !st_d.rly_cl;
	end

	// State register, defaults at reset
	always_ff @(posedge clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			st_q.thresh <= VAL_W'(pdao_pkg::THRESH_RST);
			st_q.dev <= 1'b0;
			st_q.alarm <= 1'b0;
			st_q.oc1_sel <= pdao_pkg::OC1_RST;
			st_q.oc2_sel <= pdao_pkg::OC2_RST;
			st_q.relay_sel <= pdao_pkg::RELAY_RST;
			st_q.rly_cl <= 1'b0;
			st_q.rly_op <= 1'b1;
		end
		else
			st_q <= st_d;
	end

	assign loop_deviation_flag_out = st_q.dev;
	assign fault_alarm_flag_out = st_q.alarm;
	assign deviation_threshold_param_out = st_q.thresh;
	// Changeover contact pair, released contact closed at reset
	assign relay_contact_closed_on_alarm_out = st_q.rly_cl;
	assign relay_contact_open_on_alarm_out = st_q.rly_op;

	// ****************************************
	// Terminal routing
	// ****************************************
	pdao_route u_oc1
	(
		.clk_in(clk_in),
		.sys_rst_in(sys_rst_in),
		.sel_in(st_q.oc1_sel),
		.dev_in(st_q.dev),
		.alarm_in(st_q.alarm),
		.term_out(oc1_term_out)
	);
	pdao_route u_oc2
	(
		.clk_in(clk_in),
		.sys_rst_in(sys_rst_in),
		.sel_in(st_q.oc2_sel),
		.dev_in(st_q.dev),
		.alarm_in(st_q.alarm),
		.term_out(oc2_term_out)
	);
	pdao_route u_rly
	(
		.clk_in(clk_in),
		.sys_rst_in(sys_rst_in),
		.sel_in(st_q.relay_sel),
		.dev_in(st_q.dev),
		.alarm_in(st_q.alarm),
		.term_out(relay_lvl)
	);

	// ****************************************
	// Assertions
	// ****************************************
	sequence s_fault_seen;
		fault_event_in;
	endsequence
	sequence s_clear_only;
		fault_clear_in && !fault_event_in;
	endsequence

	a_dev_above_thr: assert property (@(posedge clk_in)
		disable iff (sys_rst_in)
		(err_mag > st_q.thresh) |=> loop_deviation_flag_out)
		else $error("deviation flag not set above threshold");
	a_dev_below_thr: assert property (@(posedge clk_in)
		disable iff (sys_rst_in)
		(err_mag < st_q.thresh) |=> !loop_deviation_flag_out)
		else $error("deviation flag not cleared below threshold");
	a_dev_equal_hold: assert property (@(posedge clk_in)
		disable iff (sys_rst_in)
		(err_mag == st_q.thresh) |=> $stable(loop_deviation_flag_out))
		else $error("deviation flag moved at equal error");
	a_err_abs_value: assert property (@(posedge clk_in)
		disable iff (sys_rst_in)
		(err_mag == setpoint_in - process_in) ||
		(err_mag == process_in - setpoint_in))
		else $error("error magnitude wrong");
	a_thr_write_takes: assert property (@(posedge clk_in)
		disable iff (sys_rst_in)
		thresh_wr_in |=> deviation_threshold_param_out ==
			$past(thresh_data_in))
		else $error("threshold write lost");
	a_alarm_on_fault: assert property (@(posedge clk_in)
		disable iff (sys_rst_in)
		s_fault_seen |=> fault_alarm_flag_out)
		else $error("alarm not raised on fault");
	a_alarm_clear_off: assert property (@(posedge clk_in)
		disable iff (sys_rst_in)
		s_clear_only |=> !fault_alarm_flag_out)
		else $error("alarm not cleared");
	a_alarm_holds: assert property (@(posedge clk_in)
		disable iff (sys_rst_in)
		(fault_alarm_flag_out && !fault_clear_in) |=>
			fault_alarm_flag_out)
		else $error("alarm dropped before clear");
	a_relay_alarm: assert property (@(posedge clk_in)
		disable iff (sys_rst_in)
		(st_q.relay_sel == pdao_pkg::FN_ALARM) |->
		(relay_contact_closed_on_alarm_out == fault_alarm_flag_out))
		else $error("relay does not follow alarm");
	a_relay_pair: assert property (@(posedge clk_in)
		disable iff (sys_rst_in)
		relay_contact_closed_on_alarm_out !=
			relay_contact_open_on_alarm_out)
		else $error("relay contacts not complementary");
	a_oc1_dev_route: assert property (@(posedge clk_in)
		disable iff (sys_rst_in)
		(st_q.oc1_sel == pdao_pkg::FN_DEV) |=>
			(oc1_term_out == $past(st_q.dev)))
		else $error("terminal one does not follow deviation");
	a_oc2_alarm_route: assert property (@(posedge clk_in)
		disable iff (sys_rst_in)
		(st_q.oc2_sel == pdao_pkg::FN_ALARM) |=>
			(oc2_term_out == $past(st_q.alarm)))
		else $error("terminal two does not follow alarm");
	a_oc1_off_low: assert property (@(posedge clk_in)
		disable iff (sys_rst_in)
		((st_q.oc1_sel != pdao_pkg::FN_DEV) &&
		(st_q.oc1_sel != pdao_pkg::FN_ALARM)) |=> !oc1_term_out)
		else $error("terminal one active while off");
endmodule // pdao_top
